// [common/ccs_pkg.sv]
// Overview of operation
// R1 - invert the ADC output code when the inversion setting is on
// R2 - standby setting puts the ADC in low power and stops conversions
// R3 - two sampling schemes, normal and correlated double sampling, chosen by setting
// R4 - all sampling on rising master clock edges; master clock runs at twice conversion rate
// R5 - colour normal: sample all channels on first edge after sync, convert red, green, blue
// R6 - colour: one sync per pixel, three conversions per pixel period
// R7 - monochrome: multiplexer held on channel from setup register 2 word 2 bits 1:0
// R8 - colour: 6:1 clock to sync; setup 1 word 2 is 81h with, 80h without correlation
// R9 - monochrome: colour timing; setup 1 word 2 is 91h with, 90h without correlation
// R10 - fast monochrome: 3:1 ratio; correlated needs setup 2 word 1 bits 1:0 at zero
// R11 - maximum-speed monochrome: 2:1 ratio, setup 1 at 5Dh, no correlated sampling
// R12 - correlated: reset-level and video-level sample per channel, convert their difference
// R13 - reset sample nominal after reset; shift one earlier, or one or two later
// R14 - controller sets single-ended inputs with both channel inputs tied to video
// R15 - controller sets offset codes 1FF for positive video, OFF for negative video
// R16 - monochrome correlated: one conversion per sync period
// R17 - global offset and gain come after per-pixel corrections
// R18 - add the converting channel's restore level to each ADC result
// R19 - restore levels are 12-bit two's complement, cleared on reset
// R20 - pixel offset comes from external bus or internal defaults, by setting
// R21 - output word length programmable to 8, 10, 12 or 16 bits
// R22 - ADC gives 12-bit codes, one conversion every two master clocks
// R23 - restored result feeds the pixel offset adder
// R24 - sync sampled on rising edge, high one clock at least (code takes a rise only after two high samples); its rise restarts sequence
package ccs_pkg;

    // =====================================================================
    // widths
    localparam int unsigned ADC_BITS = 12;
    localparam int unsigned RES_BITS = 14;
    localparam int unsigned ADDR_BITS = 8;
    localparam int unsigned DATA_BITS = 16;
    localparam int unsigned ADC_LAT = 3;

    // =====================================================================
    // register offsets
    localparam logic [7:0] OFF_SETUP1_W1 = 8'h00;
    localparam logic [7:0] OFF_SETUP1_W2 = 8'h04;
    localparam logic [7:0] OFF_SETUP2_W1 = 8'h08;
    localparam logic [7:0] OFF_SETUP2_W2 = 8'h0c;
    localparam logic [7:0] OFF_DCR_RED = 8'h10;
    localparam logic [7:0] OFF_DCR_GREEN = 8'h14;
    localparam logic [7:0] OFF_DCR_BLUE = 8'h18;
    localparam logic [7:0] OFF_OUT_CFG = 8'h1c;
    localparam logic [7:0] OFF_STATUS = 8'h20;

    // =====================================================================
    // field positions
    localparam int unsigned S1W1_INV_BIT = 0;
    localparam int unsigned S1W1_STBY_BIT = 1;
    localparam int unsigned S1W2_CDS_BIT = 0;
    localparam int unsigned S1W2_MONO_BIT = 4;
    localparam int unsigned S1W2_MAX_BIT = 6;
    localparam int unsigned OCFG_POC_SRC_BIT = 2;

    // =====================================================================
    // reset values
    localparam logic [7:0] SETUP1_W1_RST = 8'h00;
    localparam logic [7:0] SETUP1_W2_RST = 8'h80;
    localparam logic [7:0] SETUP2_W1_RST = 8'h00;
    localparam logic [7:0] SETUP2_W2_RST = 8'h00;
    localparam logic [2:0] OUT_CFG_RST = 3'h0;
    localparam logic [11:0] DCR_RST = 12'h000;

    // =====================================================================
    // timing
    localparam int unsigned MCLK_NS = 10;
    localparam int unsigned CONV_PERIOD_MCLK = 2;
    localparam logic [2:0] VID_SMP_PHASE = 3'h0;
    localparam logic [2:0] RST_SMP_NOM = 3'h2;
    localparam logic [2:0] PHASE_MAX = 3'h7;

    // =====================================================================
    // types
    typedef enum logic [1:0] {RS_NOMINAL, RS_ADVANCE1, RS_RETARD1, RS_RETARD2} ccs_rs_shift_t;
    typedef enum logic [1:0] {WL_8, WL_10, WL_12, WL_16} ccs_word_len_t;

    typedef struct packed {
        logic valid;
        logic [1:0] chan;
        logic signed [RES_BITS-1:0] level;
    } ccs_result_t;

    typedef struct packed {
        logic sample_hold;
        logic reset_sample;
        logic convert;
        logic [1:0] chan;
    } ccs_ctrl_t;

    // =====================================================================
    // shared arithmetic
    function automatic logic signed [RES_BITS-1:0] dc_restore(input logic [ADC_BITS-1:0] code,
                                                             input logic inv,
                                                             input logic [11:0] lvl);
        logic [ADC_BITS-1:0] c;
        c = inv ? ~code : code;
        return $signed({2'b00, c}) + $signed({{2{lvl[11]}}, lvl});
    endfunction

    function automatic logic [2:0] rs_phase(input logic [1:0] shift);
        logic [2:0] p;
        p = RST_SMP_NOM;
        unique case (ccs_rs_shift_t'(shift))
            RS_NOMINAL: p = RST_SMP_NOM;
            RS_ADVANCE1: p = RST_SMP_NOM - 3'h1;
            RS_RETARD1: p = RST_SMP_NOM + 3'h1;
            RS_RETARD2: p = RST_SMP_NOM + 3'h2;
        endcase
        return p;
    endfunction

endpackage

// [logic/ccs_seq.sv]
// Local design decisions: the placing of the registers and the plain strobed port.
`timescale 1ns/1ns
module ccs_seq (
    // clock, reset, enable
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic i_ce,
    // register port
    input wire logic [ccs_pkg::ADDR_BITS-1:0] i_addr,
    input wire logic [ccs_pkg::DATA_BITS-1:0] i_wdata,
    input wire logic i_wr,
    input wire logic i_rd,
    output logic [ccs_pkg::DATA_BITS-1:0] o_rdata,
    // sensor side
    input wire logic i_video_sample_sync,
    // converter side
    input wire logic [ccs_pkg::ADC_BITS-1:0] i_adc_code,
    output ccs_pkg::ccs_ctrl_t o_ctrl,
    output logic o_adc_standby,
    // processing chain side
    output ccs_pkg::ccs_result_t o_result,
    output logic o_poc_src_ext,
    output logic [1:0] o_word_len
);
    import ccs_pkg::*;

    // =====================================================================
    // configuration registers
    logic [7:0] setup1_w1;
    logic [7:0] setup1_w2;
    logic [7:0] setup2_w1;
    logic [7:0] setup2_w2;
    logic [2:0] out_cfg;
    logic [11:0] dcr [3];

    logic inv;
    logic standby;
    logic correlated_double_sampling;
    logic mono;
    logic max_speed;
    logic [1:0] mono_chan;
    logic [1:0] rs_shift;

    assign inv = setup1_w1[S1W1_INV_BIT];
    assign standby = setup1_w1[S1W1_STBY_BIT];
    assign mono = setup1_w2[S1W2_MONO_BIT];
    assign max_speed = setup1_w2[S1W2_MAX_BIT];
    assign correlated_double_sampling = setup1_w2[S1W2_CDS_BIT] & ~max_speed; // R11
    assign mono_chan = (setup2_w2[1:0] == 2'h3) ? 2'h2 : setup2_w2[1:0];
    assign rs_shift = setup2_w1[1:0]; // R10

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            setup1_w1 <= SETUP1_W1_RST;
            setup1_w2 <= SETUP1_W2_RST;
        end else if (i_ce && i_wr) begin
            if (i_addr == OFF_SETUP1_W1) begin
                setup1_w1 <= i_wdata[7:0];
            end
            if (i_addr == OFF_SETUP1_W2) begin
                setup1_w2 <= i_wdata[7:0]; // R3 R8 R9
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            setup2_w1 <= SETUP2_W1_RST; // R13
            setup2_w2 <= SETUP2_W2_RST;
        end else if (i_ce && i_wr) begin
            if (i_addr == OFF_SETUP2_W1) begin
                setup2_w1 <= i_wdata[7:0];
            end
            if (i_addr == OFF_SETUP2_W2) begin
                setup2_w2 <= i_wdata[7:0];
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            out_cfg <= OUT_CFG_RST;
        end else if (i_ce && i_wr && i_addr == OFF_OUT_CFG) begin
            out_cfg <= i_wdata[2:0]; // R20 R21
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            for (int i = 0; i < 3; i++) begin
                dcr[i] <= DCR_RST; // R19
            end
        end else if (i_ce && i_wr) begin
            for (int i = 0; i < 3; i++) begin
                if (i_addr == OFF_DCR_RED + 8'(4 * i)) begin
                    dcr[i] <= i_wdata[11:0];
                end
            end
        end
    end

    // =====================================================================
    // sync pin: three flops, change accepted when the last two agree
    logic sync_s1;
    logic sync_s2;
    logic sync_s3;
    logic sync_lvl;
    logic sync_rise;

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync_s1 <= 1'b0;
            sync_s2 <= 1'b0;
            sync_s3 <= 1'b0;
        end else if (i_ce) begin
            sync_s1 <= i_video_sample_sync;
            sync_s2 <= sync_s1;
            sync_s3 <= sync_s2;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sync_lvl <= 1'b0;
        end else if (i_ce && sync_s2 == sync_s3) begin
            sync_lvl <= sync_s3;
        end
    end

    assign sync_rise = sync_s2 & sync_s3 & ~sync_lvl; // R24

    // =====================================================================
    // pixel phase sequencer
    logic [2:0] phase;
    logic tog;
    logic [2:0] next_phase;
    logic next_tog;
    ccs_ctrl_t next_ctrl;

    always_comb begin
        next_phase = sync_rise ? 3'h0 : ((phase == PHASE_MAX) ? PHASE_MAX : phase + 3'h1); // R24
        next_tog = sync_rise ? 1'b0 : ~tog;
        next_ctrl = '0;
        if (!standby) begin // R2
            if (!mono) begin
                // colour: one shared sample instant, then R, G, B every two clocks
                next_ctrl.convert = (next_phase == 3'h0 && sync_rise) ||
                                    next_phase == 3'h2 || next_phase == 3'h4; // R5 R6 R22
                next_ctrl.chan = next_phase[2:1]; // R5
                next_ctrl.sample_hold = sync_rise; // R4 R5
            end else if (correlated_double_sampling) begin
                next_ctrl.convert = sync_rise; // R16
                next_ctrl.chan = mono_chan; // R7
                next_ctrl.sample_hold = sync_rise;
            end else begin
                next_ctrl.convert = ~next_tog; // R7 R22
                next_ctrl.chan = mono_chan; // R7
                next_ctrl.sample_hold = ~next_tog;
            end
            next_ctrl.reset_sample = correlated_double_sampling && next_phase == rs_phase(rs_shift); // R12 R13
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            phase <= PHASE_MAX;
            tog <= 1'b0;
        end else if (i_ce) begin
            phase <= next_phase;
            tog <= next_tog;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_ctrl <= '0;
            o_adc_standby <= 1'b0;
        end else if (i_ce) begin
            o_ctrl <= next_ctrl; // R4
            o_adc_standby <= standby; // R2
        end
    end

    // =====================================================================
    // channel tag follows each conversion through the converter pipeline
    logic [ADC_LAT-1:0] tag_vld;
    logic [1:0] tag_chan [ADC_LAT];

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            tag_vld <= '0;
            for (int i = 0; i < ADC_LAT; i++) begin
                tag_chan[i] <= 2'h0;
            end
        end else if (i_ce) begin
            tag_vld <= {tag_vld[ADC_LAT-2:0], o_ctrl.convert};
            tag_chan[0] <= o_ctrl.chan;
            for (int i = 1; i < ADC_LAT; i++) begin
                tag_chan[i] <= tag_chan[i-1];
            end
        end
    end

    // =====================================================================
    // dc restore; result goes on to the pixel offset adder
    logic [1:0] out_chan;
    assign out_chan = tag_chan[ADC_LAT-1];

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_result <= '0;
        end else if (i_ce) begin
            o_result.valid <= tag_vld[ADC_LAT-1]; // R23
            o_result.chan <= out_chan;
            if (tag_vld[ADC_LAT-1]) begin
                o_result.level <= dc_restore(i_adc_code, inv, dcr[out_chan]); // R1 R18
            end
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_poc_src_ext <= 1'b0;
            o_word_len <= 2'h0;
        end else if (i_ce) begin
            o_poc_src_ext <= out_cfg[OCFG_POC_SRC_BIT]; // R20
            o_word_len <= out_cfg[1:0]; // R21 R17
        end
    end

    // =====================================================================
    // register reads, data valid in the following cycle only
    logic [DATA_BITS-1:0] next_rdata;

    always_comb begin
        next_rdata = '0;
        if (i_rd) begin
            unique case (i_addr)
                OFF_SETUP1_W1: next_rdata = {8'h00, setup1_w1};
                OFF_SETUP1_W2: next_rdata = {8'h00, setup1_w2};
                OFF_SETUP2_W1: next_rdata = {8'h00, setup2_w1};
                OFF_SETUP2_W2: next_rdata = {8'h00, setup2_w2};
                OFF_DCR_RED: next_rdata = {{4{dcr[0][11]}}, dcr[0]};
                OFF_DCR_GREEN: next_rdata = {{4{dcr[1][11]}}, dcr[1]};
                OFF_DCR_BLUE: next_rdata = {{4{dcr[2][11]}}, dcr[2]};
                OFF_OUT_CFG: next_rdata = {13'h0000, out_cfg};
                OFF_STATUS: next_rdata = {9'h000, standby, o_ctrl.chan, tog, phase};
                default: next_rdata = '0;
            endcase
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            o_rdata <= '0;
        end else if (i_ce) begin
            o_rdata <= next_rdata;
        end
    end

    // =====================================================================
    // checks
    default clocking cb @(posedge i_clk);
    endclocking
    default disable iff (!i_rst_b);

    chk_invert_code: assert property ( // R1
        i_ce && tag_vld[ADC_LAT-1] && inv && dcr[out_chan] == 12'h000
        |=> o_result.valid && o_result.level == $signed({2'b00, ~$past(i_adc_code)}))
        else $error("inverted code wrong");

    chk_restore_add: assert property ( // R18
        i_ce && tag_vld[ADC_LAT-1] && !inv
        |=> o_result.level - $signed({{2{$past(dcr[out_chan][11])}}, $past(dcr[out_chan])})
            == $signed({2'b00, $past(i_adc_code)}))
        else $error("restore level not added");

    chk_standby_quiet: assert property ( // R2
        i_ce && standby |=> !o_ctrl.convert && !o_ctrl.sample_hold && o_adc_standby)
        else $error("conversion during standby");

    chk_color_start: assert property ( // R5
        i_ce && !mono && !standby && sync_rise
        |=> o_ctrl.sample_hold && o_ctrl.convert && o_ctrl.chan == 2'h0 && phase == 3'h0)
        else $error("colour pixel start wrong");

    chk_color_rgb: assert property ( // R6
        o_ctrl.convert && !$past(mono) |-> o_ctrl.chan == phase[2:1] && phase inside {3'h0, 3'h2, 3'h4})
        else $error("colour channel order wrong");

    chk_mono_hold: assert property ( // R7
        o_ctrl.convert && $past(mono) |-> o_ctrl.chan == $past(mono_chan))
        else $error("monochrome channel moved");

    chk_conv_spacing: assert property ( // R22
        i_ce && o_ctrl.convert && !sync_rise |=> !o_ctrl.convert)
        else $error("conversions closer than two clocks");

    chk_mono_cds_once: assert property ( // R16
        i_ce && mono && correlated_double_sampling && !sync_rise |=> !o_ctrl.convert)
        else $error("extra monochrome correlated conversion");

    chk_reset_phase: assert property ( // R13
        o_ctrl.reset_sample |-> $past(correlated_double_sampling) && phase == rs_phase($past(rs_shift)))
        else $error("reset sample at wrong instant");

    chk_sync_restart: assert property ( // R24
        i_ce && sync_rise |=> phase == 3'h0 && !tog)
        else $error("sync rise did not restart sequence");

    chk_sync_once: assert property ( // R24
        i_ce && sync_rise |=> !sync_rise)
        else $error("one sync pulse restarted twice");

    chk_result_latency: assert property ( // R22
        i_ce && o_ctrl.convert |-> ##4 o_result.valid)
        else $error("result not ready four clocks after convert");

    chk_dcr_readback: assert property ( // R19
        i_ce && i_rd && i_addr == OFF_DCR_GREEN |=> o_rdata[11:0] == $past(dcr[1]))
        else $error("restore level readback wrong");

    cov_color_pixel: cover property (i_ce && !mono && sync_rise ##2 o_ctrl.convert ##2 o_ctrl.convert);
    cov_cds_reset: cover property (o_ctrl.reset_sample && rs_shift == 2'h3);
    cov_max_speed: cover property (max_speed && o_ctrl.convert ##2 o_ctrl.convert);
    cov_restored: cover property (o_result.valid && o_result.level < 0);

endmodule

// [dv/ccs_sensor_model.sv]
`timescale 1ns/1ns
module ccs_sensor_model #(
    parameter logic [11:0] CODE_R = 12'h800,
    parameter logic [11:0] CODE_G = 12'h400,
    parameter logic [11:0] CODE_B = 12'h100
) (
    // clock and reset
    input wire logic i_clk,
    input wire logic i_rst_b,
    // bench control
    input wire logic i_run,
    input wire logic [3:0] i_ratio,
    // device side
    input wire ccs_pkg::ccs_ctrl_t i_ctrl,
    output logic o_sync,
    output logic [11:0] o_adc_code
);
    import ccs_pkg::*;
    logic [3:0] cnt;
    logic conv_d;
    logic [1:0] chan_d;
    logic conv_d2;
    logic [1:0] chan_d2;

    // =====================================================================
    // sync pulse, two clocks wide, once per pixel, launched on rising edges
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            cnt <= 4'h0;
            o_sync <= 1'b0;
        end else if (i_run) begin
            cnt <= (cnt == i_ratio - 4'h1) ? 4'h0 : cnt + 4'h1;
            o_sync <= (cnt < 4'h2);
        end else begin
            cnt <= 4'h0;
            o_sync <= 1'b0;
        end
    end

    // =====================================================================
    // converter output: fixed code per channel, toggling junk between codes
    // single-ended inputs, offset set so zero video lands on the code floor
    // code stands in the third cycle after the convert pulse, when the device takes it
    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            conv_d <= 1'b0;
            chan_d <= 2'h0;
            conv_d2 <= 1'b0;
            chan_d2 <= 2'h0;
            o_adc_code <= 12'h000;
        end else begin
            conv_d <= i_ctrl.convert;
            chan_d <= i_ctrl.chan;
            conv_d2 <= conv_d;
            chan_d2 <= chan_d;
            if (conv_d2) begin
                o_adc_code <= (chan_d2 == 2'h0) ? CODE_R : (chan_d2 == 2'h1) ? CODE_G : CODE_B;
            end else begin
                o_adc_code <= ~o_adc_code;
            end
        end
    end
endmodule

// [dv/ccs_seq_bench.sv]
`timescale 1ns/1ns
`define CHK(got, want) begin \
    n_checks++; \
    if ((got) !== (want)) begin \
        err_total++; \
        $display("ERROR %0t: got %0h want %0h", $time, got, want); \
    end \
end
module ccs_seq_bench;
    import ccs_pkg::*;
    localparam logic [11:0] C_R = 12'h800;
    localparam logic [11:0] C_G = 12'h400;
    localparam logic [11:0] C_B = 12'h100;
    logic i_clk = 1'b0;
    logic i_rst_b, i_wr, i_rd, run_m, sync, stby, poc;
    logic [7:0] i_addr;
    logic [15:0] i_wdata, o_rdata;
    logic [11:0] adc;
    logic [1:0] wl;
    ccs_ctrl_t ctrl;
    ccs_result_t res;
    int err_total, n_checks, cyc, sh_n, last_sh;
    int conv_t[$];
    logic [1:0] conv_c[$];
    int rs_d[$];
    ccs_result_t res_q[$];
    logic [11:0] lvl[3];
    logic [11:0] code[3];
    int rs_want[4] = '{2, 1, 3, 4};

    always #5 i_clk = ~i_clk;

    ccs_seq uut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_ce(1'b1), .i_addr(i_addr), .i_wdata(i_wdata),
        .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .i_video_sample_sync(sync), .i_adc_code(adc),
        .o_ctrl(ctrl), .o_adc_standby(stby), .o_result(res), .o_poc_src_ext(poc), .o_word_len(wl));

    ccs_sensor_model #(.CODE_R(C_R), .CODE_G(C_G), .CODE_B(C_B)) sensor (.i_clk(i_clk), .i_rst_b(i_rst_b),
        .i_run(run_m), .i_ratio(4'h6), .i_ctrl(ctrl), .o_sync(sync), .o_adc_code(adc));

    // =====================================================================
    // event log
    always @(posedge i_clk) begin
        cyc++;
        if (ctrl.convert === 1'b1) begin
            conv_t.push_back(cyc);
            conv_c.push_back(ctrl.chan);
        end
        if (ctrl.sample_hold === 1'b1) begin
            sh_n++;
            last_sh = cyc;
        end
        if (ctrl.reset_sample === 1'b1)
            rs_d.push_back(cyc - last_sh);
        if (res.valid === 1'b1)
            res_q.push_back(res);
    end

    // =====================================================================
    // helpers
    function automatic logic signed [13:0] want_lvl(input logic [1:0] ch, input logic inv);
        logic [11:0] c;
        c = inv ? ~code[ch] : code[ch];
        return $signed({2'b00, c}) + $signed({{2{lvl[ch][11]}}, lvl[ch]});
    endfunction

    task automatic wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge i_clk);
        i_addr <= a;
        i_wdata <= d;
        i_wr <= 1'b1;
        @(posedge i_clk);
        i_wr <= 1'b0;
    endtask

    task automatic rd(input logic [7:0] a, input logic [15:0] want);
        @(posedge i_clk);
        i_addr <= a;
        i_rd <= 1'b1;
        @(posedge i_clk);
        i_rd <= 1'b0;
        #1;
        `CHK(o_rdata, want)
    endtask

    task automatic run(input int n);
        repeat (n) @(posedge i_clk);
        #1;
    endtask

    task automatic setup(input logic [7:0] a, input logic [15:0] d);
        wr(a, d);
        run(14);
        conv_t.delete();
        conv_c.delete();
        rs_d.delete();
        res_q.delete();
        sh_n = 0;
        run(30);
    endtask

    task automatic chk_res(input logic inv);
        `CHK(res_q.size() > 0, 1'b1)
        foreach (res_q[i]) begin
            `CHK(res_q[i].level, want_lvl(res_q[i].chan, inv))
        end
    endtask

    task automatic chk_colour;
        int k;
        int n0;
        k = 0;
        n0 = 0;
        while (k < conv_c.size() && conv_c[k] !== 2'h0)
            k++;
        for (int j = 0; j < 6; j++) begin
            `CHK(conv_c[k + j], 2'(j % 3))
            `CHK(conv_t[k + j + 1] - conv_t[k + j], 2)
        end
        foreach (conv_c[i]) begin
            if (conv_c[i] === 2'h0)
                n0++;
        end
        `CHK(sh_n, n0)
        `CHK(conv_t[k + 3] - conv_t[k], 6)
    endtask

    task automatic chk_gap(input logic [1:0] ch, input int gap, input int n);
        `CHK(conv_t.size() > n, 1'b1)
        for (int j = 0; j < n; j++) begin
            `CHK(conv_c[j], ch)
            `CHK(conv_t[j + 1] - conv_t[j], gap)
        end
    endtask

    task automatic give_verdict;
        $display("checks %0d errors %0d", n_checks, err_total);
        if (err_total == 0 && n_checks > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask

    // =====================================================================
    // tests
    initial begin
        i_rst_b = 1'b0;
        i_wr = 1'b0;
        i_rd = 1'b0;
        i_addr = 8'h00;
        i_wdata = 16'h0000;
        run_m = 1'b0;
        lvl = '{12'h080, 12'h000, 12'hfc0};
        code = '{C_R, C_G, C_B};
        repeat (20) @(posedge i_clk);
        i_rst_b <= 1'b1;
        rd(OFF_SETUP1_W1, 16'h0000);
        rd(OFF_SETUP1_W2, 16'h0080);
        rd(OFF_SETUP2_W1, 16'h0000);
        rd(OFF_DCR_RED, 16'h0000);
        rd(OFF_DCR_BLUE, 16'h0000);
        rd(OFF_DCR_GREEN, 16'h0000);
        rd(8'h24, 16'h0000);
        wr(OFF_DCR_RED, 16'h0080);
        wr(OFF_DCR_BLUE, 16'h0fc0);
        rd(OFF_DCR_BLUE, 16'hffc0);
        run_m <= 1'b1;
        setup(OFF_SETUP1_W2, 16'h0080);
        chk_colour();
        chk_res(1'b0);
        setup(OFF_SETUP1_W1, 16'h0001);
        chk_res(1'b1);
        setup(OFF_SETUP1_W1, 16'h0002);
        `CHK(stby, 1'b1)
        `CHK(conv_t.size(), 0)
        wr(OFF_SETUP1_W1, 16'h0000);
        wr(OFF_SETUP2_W2, 16'h0001);
        setup(OFF_SETUP1_W2, 16'h0090);
        `CHK(stby, 1'b0)
        chk_gap(2'h1, 2, 8);
        chk_res(1'b0);
        setup(OFF_SETUP1_W2, 16'h0091);
        chk_gap(2'h1, 6, 3);
        setup(OFF_SETUP1_W2, 16'h005d);
        chk_gap(2'h1, 2, 8);
        wr(OFF_SETUP1_W2, 16'h0081);
        for (int i = 0; i < 4; i++) begin
            setup(OFF_SETUP2_W1, 16'(i));
            `CHK(rs_d[1], rs_want[i])
        end
        for (int i = 0; i < 8; i++) begin
            wr(OFF_OUT_CFG, 16'(i));
            run(2);
            `CHK(wl, 2'(i))
            `CHK(poc, i[2])
        end
        @(posedge i_clk);
        i_rst_b <= 1'b0;
        repeat (2) @(posedge i_clk);
        i_rst_b <= 1'b1;
        rd(OFF_DCR_RED, 16'h0000);
        rd(OFF_SETUP2_W1, 16'h0000);
        give_verdict();
    end

    initial begin
        #50000;
        err_total++;
        give_verdict();
    end
endmodule
